//--- dv/ctl_flow_props.sv
// Port checker for the branch and call executor.
`timescale 1ns/100ps
module ctl_flow_props
   import ctl_flow_pkg::*;
(
   input wire logic ref_clk_in,                 // Clock.
   input wire logic sys_rst_in,                 // Reset.
   input wire logic [INSN_W-1:0] insn_in,       // Word at the program counter.
   input wire logic [7:0] accumulator_in,       // Working register.
   input wire logic [7:0] flags_in,             // Status register.
   input wire logic [PC_W-1:0] pc_out,          // Program counter.
   input wire logic flush_out,                  // No-operation cycle.
   input wire logic push_out,                   // Push strobe.
   input wire logic [STACK_W-1:0] return_stack_top_out, // Stack top.
   input wire logic [7:0] accumulator_shadow_out, // Working shadow.
   input wire logic [7:0] flags_shadow_out      // Status shadow.
);
   import ctl_flow_pkg::*;
   // Single domain, so clock and reset are given once.
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (sys_rst_in);
   property p_pc_even; pc_out[0] == 1'b0; endproperty
   a_pc_even: assert property (p_pc_even) else $error("pc bit 0 set");
   property p_push_pulse; push_out |=> !push_out; endproperty
   a_push_pulse: assert property (p_push_pulse) else $error("push too long");
   property p_push_tos; push_out |-> return_stack_top_out == PC_W'(pc_out + CALL_RET_OFS); endproperty
   a_push_tos: assert property (p_push_tos) else $error("stack top wrong");
   property p_call_flush; push_out |=> flush_out [*4] ##1 !flush_out; endproperty
   a_call_flush: assert property (p_call_flush) else $error("call flush wrong");
   property p_flush_hold; $rose(flush_out) |=> $stable(pc_out) [*4]; endproperty
   a_flush_hold: assert property (p_flush_hold) else $error("pc moved in flush");
   property p_pc_spacing; !$stable(pc_out) |=> $stable(pc_out) [*3]; endproperty
   a_pc_spacing: assert property (p_pc_spacing) else $error("pc moved early");
   property p_fast; push_out && insn_in[8] |-> accumulator_shadow_out == $past(accumulator_in)
      && flags_shadow_out == $past(flags_in); endproperty
   a_fast: assert property (p_fast) else $error("shadow not saved");
   property p_no_save; !$stable(flags_shadow_out) |-> push_out && insn_in[8]; endproperty
   a_no_save: assert property (p_no_save) else $error("shadow changed");
   c_fast: cover property (push_out && insn_in[8]);
   c_slow: cover property (push_out && !insn_in[8]);
   c_flush: cover property ($rose(flush_out) && !$past(push_out));
endmodule
bind branch_zero_and_call_exec ctl_flow_props props_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
   .insn_in(insn_in), .accumulator_in(accumulator_in), .flags_in(flags_in), .pc_out(pc_out),
   .flush_out(flush_out), .push_out(push_out), .return_stack_top_out(return_stack_top_out),
   .accumulator_shadow_out(accumulator_shadow_out), .flags_shadow_out(flags_shadow_out));

//--- dv/prog_mem.sv
// Program memory model feeding instruction words to the executor.
`timescale 1ns/100ps
module prog_mem
   import ctl_flow_pkg::*;
(
   input wire logic [ctl_flow_pkg::PC_W-1:0] pc_in,          // Fetch address.
   output logic [ctl_flow_pkg::INSN_W-1:0] insn_out,         // Word at the address.
   output logic [ctl_flow_pkg::INSN_W-1:0] insn_next_out     // Word after it.
);
   import ctl_flow_pkg::*;
   // Only 512 words exist, so high addresses alias onto low ones.
   logic [INSN_W-1:0] mem [512] = '{default: 16'h0000};
   assign insn_out = mem[pc_in[9:1]];
   assign insn_next_out = mem[pc_in[9:1] + 9'h001];
endmodule

//--- dv/testbench.sv
// Self-checking testbench for the branch and call executor.
`timescale 1ns/100ps
module testbench;
   import ctl_flow_pkg::*;
   logic ref_clk_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic zero_flag_in = 1'b0;
   logic [7:0] acc = 8'hA5, flg = 8'h3C, bsel = 8'h0F;
   logic [INSN_W-1:0] insn, insn_nx;
   logic [PC_W-1:0] pc, stack_top;
   logic [1:0] qph;
   logic flush, push;
   logic [7:0] acc_s, flg_s, bsel_s;
   int mismatches = 0;
   int checked = 0;
   always #4 ref_clk_in = ~ref_clk_in;
   prog_mem pm_u (.pc_in(pc), .insn_out(insn), .insn_next_out(insn_nx));
   branch_zero_and_call_exec dut_u (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .insn_in(insn),
      .insn_next_in(insn_nx), .zero_flag_in(zero_flag_in), .accumulator_in(acc), .flags_in(flg),
      .bank_select_reg_in(bsel), .pc_out(pc), .qph_out(qph), .flush_out(flush), .push_out(push),
      .return_stack_top_out(stack_top), .accumulator_shadow_out(acc_s), .flags_shadow_out(flg_s),
      .bank_select_shadow_out(bsel_s));
   task automatic chk(input string name, input logic [PC_W-1:0] exp, input logic [PC_W-1:0] got);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask
   // Sets the zero flag before Q4, waits a bounded time for the next pc load.
   task automatic step(input logic [PC_W-1:0] exp_pc, input logic exp_fl, input logic z);
      logic [PC_W-1:0] old;
      int n;
      old = pc;
      n = 0;
      @(posedge ref_clk_in) zero_flag_in <= z;
      #1;
      while (pc === old && n < 16) begin
         @(posedge ref_clk_in);
         #1;
         n++;
      end
      chk("pc", exp_pc, pc);
      chk("flush", 21'(exp_fl), 21'(flush));
      chk("phase", 21'(Q4), 21'(qph));
   endtask
   task automatic t_reset();
      #1;
      chk("pc", PC_RST, pc);
      chk("stack top", 21'h0_0000, stack_top);
      chk("shadow", 21'h0_0000, 21'({acc_s, flg_s}));
      chk("bank shadow", 21'h0_0000, 21'(bsel_s));
   endtask
   task automatic t_branch();
      step(21'h0_0002, 1'b0, 1'b0);
      step(21'h0_0102, 1'b1, 1'b1);
      step(21'h0_0004, 1'b1, 1'b1);
      step(21'h0_0006, 1'b0, 1'b1);
   endtask
   task automatic t_call();
      step(21'h10_0020, 1'b1, 1'b0);
      chk("stack top", 21'h0_000A, stack_top);
      chk("shadow", 21'h00_A53C, 21'({acc_s, flg_s}));
      chk("bank shadow", 21'h0_000F, 21'(bsel_s));
      @(posedge ref_clk_in) acc <= 8'h5A;
      step(21'h0_0030, 1'b1, 1'b0);
      chk("stack top", 21'h10_0024, stack_top);
      chk("shadow", 21'h00_A53C, 21'({acc_s, flg_s}));
   endtask
   task automatic t_refuse();
      step(21'h0_0032, 1'b0, 1'b0);
      chk("stack top", 21'h10_0024, stack_top);
   endtask
   task automatic close_out();
      if (mismatches == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   initial begin
      #5000;
      mismatches++;
      close_out();
   end
   initial begin
      pm_u.mem[0] = 16'hE005;
      pm_u.mem[1] = 16'hE07F;
      pm_u.mem[129] = 16'hE080;
      pm_u.mem[2] = 16'hE105;
      pm_u.mem[3] = 16'hED10;
      pm_u.mem[4] = 16'hF800;
      pm_u.mem[16] = 16'hEC18;
      pm_u.mem[17] = 16'hF000;
      pm_u.mem[24] = 16'hEC40;
      pm_u.mem[25] = 16'h1234;
      repeat (2) @(posedge ref_clk_in);
      sys_rst_in <= 1'b0;
      t_reset();
      t_branch();
      t_call();
      t_refuse();
      close_out();
   end
endmodule

//--- src/branch_zero_and_call_exec.sv
// Executor for the branch-if-zero and two-word call instructions of the core.
`timescale 1ns/100ps
// Overview of operation
// - Zero set: PC gets PC+2+2n, else next.
// - Offset is signed 8-bit, doubled, added.
// - Branch opcode is upper byte 1110_0000.
// - Branch: one cycle, two when taken.
// - Branch decodes Q1, literal Q2, PC Q4.
// - Call: 1110_110s+k7:0, then 1111+k19:8.
// - Call pushes PC+4 as stack top.
// - Fast bit saves W, flags, bank shadows.
// - Call target goes into PC bits 20:1.
// - Call takes two cycles, push in Q3.
module branch_zero_and_call_exec
   import ctl_flow_pkg::*;
(
   input wire logic ref_clk_in,                    // 125 MHz system clock.
   input wire logic sys_rst_in,                    // Synchronous reset, active high.
   input wire logic [INSN_W-1:0] insn_in,          // Instruction word at the current PC.
   input wire logic [INSN_W-1:0] insn_next_in,     // Word at PC+2, the call's second word.
   input wire logic zero_flag_in,                  // Zero flag of the status register.
   input wire logic [7:0] accumulator_in,          // Working register value.
   input wire logic [7:0] flags_in,                // Status register value.
   input wire logic [7:0] bank_select_reg_in,      // Bank select register value.
   output logic [PC_W-1:0] pc_out,                 // Program counter.
   output logic [1:0] qph_out,                     // Current quarter phase.
   output logic flush_out,                         // High during the no-operation cycle.
   output logic push_out,                          // One-cycle stack push strobe in Q3.
   output logic [STACK_W-1:0] return_stack_top_out, // Top of the return stack.
   output logic [7:0] accumulator_shadow_out,      // Working register shadow.
   output logic [7:0] flags_shadow_out,            // Status register shadow.
   output logic [7:0] bank_select_shadow_out       // Bank select shadow.
);
   import ctl_flow_pkg::*;

   // Phase source: the instruction cycle is four clocks.
   logic [1:0] qph;
   logic q4;

   quarter_phase u_qph (
      .ref_clk_in(ref_clk_in),
      .sys_rst_in(sys_rst_in),
      .qph_out(qph),
      .q4_out(q4)
   );

   // Whole state of the executor.
   typedef struct packed {
      exec_st_e st;
      logic [PC_W-1:0] pc;
      logic [7:0] ofs;
      logic [7:0] klo;
      logic fast;
      logic is_branch;
      logic is_call;
      logic push;
      logic [1:0] qph;
      logic flush;
      logic [STACK_W-1:0] ret_top;
      logic [7:0] acc_sh;
      logic [7:0] ss;
      logic [7:0] bs;
   } exec_s;

   exec_s ex_r;
   exec_s ex_nxt;

   // Decodes the branch-if-zero opcode from the upper byte.
   function automatic logic is_branch_zero_op(input logic [INSN_W-1:0] w);
      is_branch_zero_op = (w[15:8] == BRANCH_ZERO_OPC);
   endfunction

   // Decodes the first word of the call.
   function automatic logic is_call_op(input logic [INSN_W-1:0] w);
      is_call_op = (w[15:9] == CALL_OPC);
   endfunction

   // Branch target arithmetic; sign extension keeps negative offsets correct.
   function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] pc, input logic [7:0] n);
      logic [PC_W-1:0] twice_n;
      twice_n = {{(PC_W-9){n[7]}}, n, 1'b0};
      branch_target = PC_W'(pc + PC_STEP + twice_n);
   endfunction

   // Next-state logic, stepping through the quarter phases.
   always_comb begin
      ex_nxt = ex_r;
      ex_nxt.push = 1'b0;
      ex_nxt.qph = qph;
      unique case (ex_r.st)
         ST_EXEC: begin
            unique case (qph)
               Q1: begin
                  // Decode; the status flags are only read, never written.
                  ex_nxt.is_branch = is_branch_zero_op(insn_in);
                  ex_nxt.is_call = is_call_op(insn_in);
                  ex_nxt.fast = insn_in[8];
               end
               Q2: begin
                  // Literal read: branch offset or target bits 7:0.
                  ex_nxt.ofs = insn_in[7:0];
                  ex_nxt.klo = insn_in[7:0];
               end
               Q3: begin
                  // Call pushes the return address and optionally the shadows.
                  // A first word without a valid second word is no call, so nothing is pushed.
                  if (ex_r.is_call && insn_next_in[15:12] == CALL2_OPC) begin
                     ex_nxt.ret_top = STACK_W'(ex_r.pc + CALL_RET_OFS);
                     ex_nxt.push = 1'b1;
                     if (ex_r.fast) begin
                        ex_nxt.acc_sh = accumulator_in;
                        ex_nxt.ss = flags_in;
                        ex_nxt.bs = bank_select_reg_in;
                     end
                  end
               end
               Q4: begin
                  if (ex_r.is_call && insn_next_in[15:12] == CALL2_OPC) begin
                     // Target lands on bits 20:1, bit 0 forced low.
                     ex_nxt.pc = {insn_next_in[11:0], ex_r.klo, 1'b0};
                     ex_nxt.st = ST_FLUSH;
                     ex_nxt.flush = 1'b1;
                  end else if (ex_r.is_branch && zero_flag_in) begin
                     // Taken branch writes PC and costs a second cycle.
                     ex_nxt.pc = branch_target(ex_r.pc, ex_r.ofs) & ~PC_W'(1);
                     ex_nxt.st = ST_FLUSH;
                     ex_nxt.flush = 1'b1;
                  end else begin
                     // Not taken or other instruction: single cycle.
                     ex_nxt.pc = PC_W'(ex_r.pc + PC_STEP);
                  end
                  ex_nxt.is_branch = 1'b0;
                  ex_nxt.is_call = 1'b0;
               end
            endcase
         end
         ST_FLUSH: begin
            // No operation while the target is fetched.
            if (q4) begin
               ex_nxt.st = ST_EXEC;
               ex_nxt.flush = 1'b0;
            end
         end
         default: begin
            ex_nxt.st = ST_EXEC;
         end
      endcase
   end

   // State register.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         ex_r <= '{st: ST_EXEC, pc: PC_RST, ofs: REG8_RST, klo: REG8_RST, fast: 1'b0,
                   is_branch: 1'b0, is_call: 1'b0, push: 1'b0, qph: QPH_RST, flush: 1'b0,
                   ret_top: PC_RST, acc_sh: REG8_RST, ss: REG8_RST, bs: REG8_RST};
      end else begin
         ex_r <= ex_nxt;
      end
   end

   // Outputs straight from the state flip-flops.
   assign pc_out = ex_r.pc;
   assign qph_out = ex_r.qph;
   assign flush_out = ex_r.flush;
   assign push_out = ex_r.push;
   assign return_stack_top_out = ex_r.ret_top;
   assign accumulator_shadow_out = ex_r.acc_sh;
   assign flags_shadow_out = ex_r.ss;
   assign bank_select_shadow_out = ex_r.bs;
endmodule

//--- src/ctl_flow_pkg.sv
// Package with encodings, widths and reset values for the branch and call executor.
package ctl_flow_pkg;

   // Program counter and instruction widths.
   localparam int PC_W = 21;
   localparam int INSN_W = 16;
   localparam int STACK_W = 21;

   // Opcode patterns.
   localparam logic [7:0] BRANCH_ZERO_OPC = 8'hE0;
   localparam logic [6:0] CALL_OPC = 7'h76;
   localparam logic [3:0] CALL2_OPC = 4'hF;

   // Program counter increments in bytes.
   localparam logic [PC_W-1:0] PC_STEP = 21'h0_0002;
   localparam logic [PC_W-1:0] CALL_RET_OFS = 21'h0_0004;

   // Reset values.
   localparam logic [PC_W-1:0] PC_RST = 21'h0_0000;
   localparam logic [7:0] REG8_RST = 8'h00;
   localparam logic [1:0] QPH_RST = 2'h0;

   // Quarter phases of one instruction cycle.
   localparam logic [1:0] Q1 = 2'h0;
   localparam logic [1:0] Q2 = 2'h1;
   localparam logic [1:0] Q3 = 2'h2;
   localparam logic [1:0] Q4 = 2'h3;

   // Executor states.
   typedef enum logic [1:0] {
      ST_EXEC,
      ST_FLUSH
   } exec_st_e;

endpackage

//--- src/quarter_phase.sv
// Quarter phase generator producing Q1..Q4 and the Q4 instruction boundary strobe.
`timescale 1ns/100ps
module quarter_phase
   import ctl_flow_pkg::*;
(
   input wire logic ref_clk_in,  // System clock.
   input wire logic sys_rst_in,  // Synchronous reset, active high.
   output logic [1:0] qph_out,   // Current quarter phase.
   output logic q4_out           // High during Q4.
);
   import ctl_flow_pkg::*;

   // All state in one struct.
   typedef struct packed {
      logic [1:0] qph;
   } qp_s;

   qp_s qp_r;
   qp_s qp_nxt;

   // Advance the phase every clock; reset lands on Q1.
   always_comb begin
      qp_nxt = qp_r;
      qp_nxt.qph = 2'(qp_r.qph + 2'h1);
   end

   // Register the phase.
   always_ff @(posedge ref_clk_in) begin
      if (sys_rst_in) begin
         qp_r <= '{qph: QPH_RST};
      end else begin
         qp_r <= qp_nxt;
      end
   end

   assign qph_out = qp_r.qph;
   assign q4_out = (qp_r.qph == Q4);
endmodule
